/* hdl/swdt_consts.vh */
/*
 * Constants of the staged watchdog: register byte offsets, field
 * positions, reset values, write key and expiry action codes.
 * Assumes byte addresses on an 8-bit register port with 32-bit data.
 */
`ifndef SWDT_CONSTS_VH
`define SWDT_CONSTS_VH

// ****************************************
// main-system watchdog register offsets
// ****************************************
`define SWDT_MAIN_CFG 8'h48
`define SWDT_MAIN_PRESCALE 8'h4C
`define SWDT_MAIN_TMO0 8'h50
`define SWDT_MAIN_TMO3 8'h5C
`define SWDT_MAIN_FEED 8'h60
`define SWDT_MAIN_WKEY 8'h64

// ****************************************
// rtc-domain watchdog and status offsets
// ****************************************
`define SWDT_RTC_CFG 8'h80
`define SWDT_RTC_TMO0 8'h84
`define SWDT_RTC_TMO3 8'h90
`define SWDT_RTC_FEED 8'h94
`define SWDT_RTC_WKEY 8'h98
`define SWDT_STATUS 8'h9C
`define SWDT_MAIN_COUNT 8'hA0
`define SWDT_RTC_COUNT 8'hA4

// ****************************************
// fields, key and reset values
// ****************************************
`define SWDT_CFG_EN 31
`define SWDT_CFG_BOOT 12
`define SWDT_ST_MAIN_IRQ 4
`define SWDT_ST_RTC_IRQ 5
`define SWDT_KEY 32'h50D8_3AA1
`define SWDT_KEY_RST 32'h0000_0000
`define SWDT_MAIN_CFG_BOOT_RST 32'h8000_1003
`define SWDT_RTC_CFG_RST 32'h8000_1004
`define SWDT_CFG_IDLE_RST 32'h0000_0000
`define SWDT_TMO_RST 32'h0001_0000
`define SWDT_PRESCALE_RST 16'h0001

// ****************************************
// expiry action codes, 3 bits per stage
// ****************************************
`define SWDT_ACT_OFF 3'h0
`define SWDT_ACT_IRQ 3'h1
`define SWDT_ACT_CPU 3'h2
`define SWDT_ACT_MAIN 3'h3
`define SWDT_ACT_ALL 3'h4

`endif

/* hdl/swdt_prescale.v */
/*
 * Clock-enable divider for the main-system watchdog: one tick every
 * div_value cycles of clk (a value of 0 acts as 1).
 * Assumes rst_n is already synchronised to clk.
 */
`timescale 1ns/1ns
module swdt_prescale #(
   parameter PW = 16
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire run,
   input wire [PW-1:0] div_value,
   // divided enable
   output reg tick
);

reg [PW-1:0] cnt;

always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      cnt <= {PW{1'b0}};
      tick <= 1'b0;
   end
   else if (!run)
   begin
      // restart from zero so the first tick is a full period away
      cnt <= {PW{1'b0}};
      tick <= 1'b0;
   end
   else if (cnt + {{(PW-1){1'b0}}, 1'b1} >= div_value)
   begin
      cnt <= {PW{1'b0}};
      tick <= 1'b1;
   end
   else
   begin
      cnt <= cnt + {{(PW-1){1'b0}}, 1'b1};
      tick <= 1'b0;
   end
end

endmodule

/* hdl/swdt_core.v */
/*
 * Four-stage expiry engine shared by both watchdog variants: counter,
 * stage pointer and one-cycle expiry pulse with the stage's action.
 * Assumes tick is a one-cycle enable on clk and rst_n is synchronised.
 */
`timescale 1ns/1ns
module swdt_core #(
   parameter CW = 32
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control
   input wire tick,
   input wire enable,
   input wire feed,
   input wire restore,
   // stage timeouts and actions
   input wire [CW-1:0] tmo0,
   input wire [CW-1:0] tmo1,
   input wire [CW-1:0] tmo2,
   input wire [CW-1:0] tmo3,
   input wire [11:0] act_cfg,
   // state
   output reg [1:0] stage,
   output reg [CW-1:0] count,
   output reg expire,
   output reg [2:0] expire_act
);

reg [CW-1:0] tmo_sel;
wire [CW:0] count_inc;

assign count_inc = {1'b0, count} + {{CW{1'b0}}, 1'b1};

always @*
begin
   case (stage)
      2'd0: tmo_sel = tmo0;
      2'd1: tmo_sel = tmo1;
      2'd2: tmo_sel = tmo2;
      default: tmo_sel = tmo3;
   endcase
end

always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      stage <= 2'd0;
      count <= {CW{1'b0}};
      expire <= 1'b0;
      expire_act <= 3'd0;
   end
   else
   begin
      expire <= 1'b0;
      if (restore || feed)
      begin
         stage <= 2'd0;
         count <= {CW{1'b0}};
      end
      else if (enable && tick)
      begin
         if (count_inc >= {1'b0, tmo_sel})
         begin
            expire <= 1'b1;
            expire_act <= act_cfg[3*stage +: 3];
            count <= {CW{1'b0}};
            stage <= stage + 2'd1;
         end
         else
         begin
            count <= count_inc[CW-1:0];
         end
      end
   end
end

endmodule

/* hdl/swdt_top.v */
/*
 * Staged watchdog block: a main-system watchdog counting prescaled clk
 * ticks and an rtc-domain watchdog counting slow-clock edges, with
 * key-guarded registers on a plain strobe port and reset requests out.
 * Assumes the slow clock pin is far slower than clk and that the system
 * reset logic turns the request pulses into resets.
 */
//
// Summary of operation
// - each watchdog has a 32-bit counter incrementing per source tick.
// - main watchdog ticks from clk through a programmable 16-bit divider.
// - rtc watchdog counts slow clock edges directly, no divider.
// - counting and expiry actions happen only while enabled.
// - on timeout: fire stage action, clear counter, advance stage.
// - four stages 0 to 3, wrapping from 3 to 0.
// - any write to the feed register while the key unlocks returns to stage 0, counter 0.
// - each stage has its own timeout register.
// - rtc stage 0 timeout is its value shifted by fuse select plus one.
// - per-stage action chosen in one config register, including off.
// - main-system reset resets main watchdog, leaves rtc domain alone.
// - only rtc watchdog offers the main plus rtc reset action.
// - writes except to the key register ignored unless key unlocks.
// - main watchdog of group zero enabled at boot, stage 0 resets.
// - rtc watchdog enabled at boot, stage 0 resets main plus rtc.
// - main timeouts are counted in prescaled watchdog ticks.
`timescale 1ns/1ns
`include "swdt_consts.vh"
module swdt_top #(
   parameter TIMER_GROUP_ZERO = 1,
   parameter SEL_W = 2
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rdata,
   // slow clock and fuse inputs
   input wire rtc_slow_clk_pin,
   input wire [SEL_W-1:0] fused_stage0_shift_sel,
   // interrupt flags
   output reg main_wdog_irq,
   output reg rtc_wdog_irq,
   // reset requests
   output reg cpu_reset_req,
   output reg main_sys_reset_req,
   output reg full_sys_reset_req
);

// ****************************************
// reset synchroniser
// ****************************************
reg rst_meta_n;
reg rst_sync_n;

always @(posedge clk or negedge rst_n)
begin
   if (!rst_n)
   begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
   end
   else
   begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
   end
end

// ****************************************
// pin synchronisers
// ****************************************
reg slow_meta;
reg slow_sync;
reg slow_last;
reg [SEL_W-1:0] sel_meta;
reg [SEL_W-1:0] sel_sync;

always @(posedge clk or negedge rst_sync_n)
begin
   if (!rst_sync_n)
   begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_last <= 1'b0;
      sel_meta <= {SEL_W{1'b0}};
      sel_sync <= {SEL_W{1'b0}};
   end
   else
   begin
      slow_meta <= rtc_slow_clk_pin;
      slow_sync <= slow_meta;
      slow_last <= slow_sync;
      sel_meta <= fused_stage0_shift_sel;
      sel_sync <= sel_meta;
   end
end

// one enable per rising slow clock edge
wire slow_tick = slow_sync & ~slow_last;

// ****************************************
// helper functions
// ****************************************
// maps a code to the action actually taken by a watchdog variant
function [2:0] act_eff;
   input [2:0] code;
   input is_rtc;
   begin
      if (code == `SWDT_ACT_ALL && !is_rtc)
         act_eff = `SWDT_ACT_OFF;
      else if (code > `SWDT_ACT_ALL)
         act_eff = `SWDT_ACT_OFF;
      else
         act_eff = code;
   end
endfunction

// while the boot guard holds, stage 0 is forced to its boot action
function [11:0] act_cfg;
   input [31:0] cfg;
   input [2:0] boot_act;
   begin
      act_cfg = cfg[11:0];
      if (cfg[`SWDT_CFG_BOOT])
         act_cfg[2:0] = boot_act;
   end
endfunction

// ****************************************
// registers
// ****************************************
localparam [31:0] MAIN_CFG_RST = (TIMER_GROUP_ZERO != 0) ?
   `SWDT_MAIN_CFG_BOOT_RST : `SWDT_CFG_IDLE_RST;

reg [31:0] main_wdog_action_config;
reg [15:0] main_wdog_prescale_value;
reg [31:0] main_tmo [0:3];
reg [31:0] main_wdog_write_key;
reg [31:0] rtc_wdog_action_config;
reg [31:0] rtc_tmo [0:3];
reg [31:0] rtc_wdog_write_key;
reg main_restore;
integer i;
integer j;
wire main_open = (main_wdog_write_key == `SWDT_KEY);
wire rtc_open = (rtc_wdog_write_key == `SWDT_KEY);
wire main_wr = wr_en && main_open;
wire rtc_wr = wr_en && rtc_open;
wire main_tmo_hit = (addr >= `SWDT_MAIN_TMO0) &&
   (addr <= `SWDT_MAIN_TMO3) && (addr[1:0] == 2'd0);
wire rtc_tmo_hit = (addr >= `SWDT_RTC_TMO0) &&
   (addr <= `SWDT_RTC_TMO3) && (addr[1:0] == 2'd0);
// main slots start on a 16-byte boundary, so bits 3:2 are the stage
wire [1:0] main_idx = addr[3:2];
wire [1:0] rtc_idx = addr[3:2] - 2'd1;
wire main_feed_req = main_wr && addr == `SWDT_MAIN_FEED;
wire rtc_feed_req = rtc_wr && addr == `SWDT_RTC_FEED;
// boot guard keeps the watchdog running until software releases it
wire main_wdog_enable = main_wdog_action_config[`SWDT_CFG_EN] |
   main_wdog_action_config[`SWDT_CFG_BOOT];
wire rtc_wdog_enable = rtc_wdog_action_config[`SWDT_CFG_EN] |
   rtc_wdog_action_config[`SWDT_CFG_BOOT];

// main-side registers; a main-system reset request restores them
always @(posedge clk or negedge rst_sync_n)
begin
   if (!rst_sync_n)
   begin
      main_wdog_action_config <= MAIN_CFG_RST;
      main_wdog_prescale_value <= `SWDT_PRESCALE_RST;
      main_wdog_write_key <= `SWDT_KEY_RST;
      for (i = 0; i < 4; i = i + 1)
         main_tmo[i] <= `SWDT_TMO_RST;
   end
   else if (main_restore)
   begin
      main_wdog_action_config <= MAIN_CFG_RST;
      main_wdog_prescale_value <= `SWDT_PRESCALE_RST;
      main_wdog_write_key <= `SWDT_KEY_RST;
      for (i = 0; i < 4; i = i + 1)
         main_tmo[i] <= `SWDT_TMO_RST;
   end
   else if (wr_en && addr == `SWDT_MAIN_WKEY)
      main_wdog_write_key <= wdata;
   else if (main_wr && addr == `SWDT_MAIN_CFG)
      main_wdog_action_config <= wdata;
   else if (main_wr && addr == `SWDT_MAIN_PRESCALE)
      main_wdog_prescale_value <= wdata[15:0];
   else if (main_wr && main_tmo_hit)
      main_tmo[main_idx] <= wdata;
end

// rtc-side registers are untouched by a main-system reset
always @(posedge clk or negedge rst_sync_n)
begin
   if (!rst_sync_n)
   begin
      rtc_wdog_action_config <= `SWDT_RTC_CFG_RST;
      rtc_wdog_write_key <= `SWDT_KEY_RST;
      for (j = 0; j < 4; j = j + 1)
         rtc_tmo[j] <= `SWDT_TMO_RST;
   end
   else if (wr_en && addr == `SWDT_RTC_WKEY)
      rtc_wdog_write_key <= wdata;
   else if (rtc_wr && addr == `SWDT_RTC_CFG)
      rtc_wdog_action_config <= wdata;
   else if (rtc_wr && rtc_tmo_hit)
      rtc_tmo[rtc_idx] <= wdata;
end

// ****************************************
// watchdog engines
// ****************************************
wire main_tick;
wire [1:0] main_stage;
wire [31:0] main_count;
wire main_expire;
wire [2:0] main_raw_act;
wire [1:0] rtc_stage;
wire [31:0] rtc_count;
wire rtc_expire;
wire [2:0] rtc_raw_act;

// effective rtc stage 0 hold: programmed value << (fuse select + 1)
wire [31:0] rtc_stage0_timeout = rtc_tmo[0] <<
   ({1'b0, sel_sync} + {{SEL_W{1'b0}}, 1'b1});

swdt_prescale #(
   .PW(16)
) u_main_div (
   .clk(clk),
   .rst_n(rst_sync_n),
   .run(main_wdog_enable & ~main_restore),
   .div_value(main_wdog_prescale_value),
   .tick(main_tick)
);

swdt_core #(
   .CW(32)
) u_main_core (
   .clk(clk),
   .rst_n(rst_sync_n),
   .tick(main_tick),
   .enable(main_wdog_enable),
   .feed(main_feed_req),
   .restore(main_restore),
   .tmo0(main_tmo[0]),
   .tmo1(main_tmo[1]),
   .tmo2(main_tmo[2]),
   .tmo3(main_tmo[3]),
   .act_cfg(act_cfg(main_wdog_action_config, `SWDT_ACT_MAIN)),
   .stage(main_stage),
   .count(main_count),
   .expire(main_expire),
   .expire_act(main_raw_act)
);

swdt_core #(
   .CW(32)
) u_rtc_core (
   .clk(clk),
   .rst_n(rst_sync_n),
   .tick(slow_tick),
   .enable(rtc_wdog_enable),
   .feed(rtc_feed_req),
   .restore(1'b0),
   .tmo0(rtc_stage0_timeout),
   .tmo1(rtc_tmo[1]),
   .tmo2(rtc_tmo[2]),
   .tmo3(rtc_tmo[3]),
   .act_cfg(act_cfg(rtc_wdog_action_config, `SWDT_ACT_ALL)),
   .stage(rtc_stage),
   .count(rtc_count),
   .expire(rtc_expire),
   .expire_act(rtc_raw_act)
);

wire [2:0] main_act = main_expire ? act_eff(main_raw_act, 1'b0) :
   `SWDT_ACT_OFF;
wire [2:0] rtc_act = rtc_expire ? act_eff(rtc_raw_act, 1'b1) :
   `SWDT_ACT_OFF;

// ****************************************
// expiry actions
// ****************************************
wire clr_main_irq = main_wr && addr == `SWDT_STATUS &&
   wdata[`SWDT_ST_MAIN_IRQ];
wire clr_rtc_irq = rtc_wr && addr == `SWDT_STATUS &&
   wdata[`SWDT_ST_RTC_IRQ];

always @(posedge clk or negedge rst_sync_n)
begin
   if (!rst_sync_n)
   begin
      main_wdog_irq <= 1'b0;
      rtc_wdog_irq <= 1'b0;
      cpu_reset_req <= 1'b0;
      main_sys_reset_req <= 1'b0;
      full_sys_reset_req <= 1'b0;
      main_restore <= 1'b0;
   end
   else
   begin
      // a new expiry wins over a clear in the same cycle
      if (main_act == `SWDT_ACT_IRQ)
         main_wdog_irq <= 1'b1;
      else if (clr_main_irq)
         main_wdog_irq <= 1'b0;
      if (rtc_act == `SWDT_ACT_IRQ)
         rtc_wdog_irq <= 1'b1;
      else if (clr_rtc_irq)
         rtc_wdog_irq <= 1'b0;
      cpu_reset_req <= (main_act == `SWDT_ACT_CPU) ||
         (rtc_act == `SWDT_ACT_CPU);
      main_sys_reset_req <= (main_act == `SWDT_ACT_MAIN) ||
         (rtc_act == `SWDT_ACT_MAIN);
      full_sys_reset_req <= (rtc_act == `SWDT_ACT_ALL);
      // main watchdog re-arms itself on any main-system reset it sees
      main_restore <= (main_act == `SWDT_ACT_MAIN) ||
         (rtc_act == `SWDT_ACT_MAIN) ||
         (rtc_act == `SWDT_ACT_ALL);
   end
end

// ****************************************
// register read
// ****************************************
always @(posedge clk or negedge rst_sync_n)
begin
   if (!rst_sync_n)
      rdata <= 32'h0000_0000;
   else if (!rd_en)
      rdata <= 32'h0000_0000;
   else if (addr == `SWDT_MAIN_CFG)
      rdata <= main_wdog_action_config;
   else if (addr == `SWDT_MAIN_PRESCALE)
      rdata <= {16'h0000, main_wdog_prescale_value};
   else if (main_tmo_hit)
      rdata <= main_tmo[main_idx];
   else if (addr == `SWDT_MAIN_WKEY)
      rdata <= main_wdog_write_key;
   else if (addr == `SWDT_RTC_CFG)
      rdata <= rtc_wdog_action_config;
   else if (rtc_tmo_hit)
      rdata <= rtc_tmo[rtc_idx];
   else if (addr == `SWDT_RTC_WKEY)
      rdata <= rtc_wdog_write_key;
   else if (addr == `SWDT_STATUS)
      rdata <= {26'h000_0000, rtc_wdog_irq, main_wdog_irq,
         rtc_stage, main_stage};
   else if (addr == `SWDT_MAIN_COUNT)
      rdata <= main_count;
   else if (addr == `SWDT_RTC_COUNT)
      rdata <= rtc_count;
   else
      rdata <= 32'h0000_0000;  // feed registers and holes read zero
end

endmodule

/* bench/swdt_top_asserts.sv */
/*
 * Checker for the staged watchdog top: reset request pulses, sticky
 * flags, status and key read-back, slow clock causality.
 * Assumes it is bound to swdt_top and sees only its ports.
 */
`timescale 1ns/1ns
`include "swdt_consts.vh"
module swdt_top_asserts #(
   parameter SEL_W = 2
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // register port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   input wire [31:0] rdata,
   // slow clock and fuse
   input wire rtc_slow_clk_pin,
   input wire [SEL_W-1:0] fused_stage0_shift_sel,
   // flags and requests
   input wire main_wdog_irq,
   input wire rtc_wdog_irq,
   input wire cpu_reset_req,
   input wire main_sys_reset_req,
   input wire full_sys_reset_req
);
   // ****************************************
   // helper logic
   // ****************************************
   reg pin_q;
   reg [3:0] since_edge;
   reg req_q;
   wire req = main_sys_reset_req | full_sys_reset_req;
   wire st_wr = wr_en && addr == `SWDT_STATUS;
   wire main_clr = st_wr && wdata[`SWDT_ST_MAIN_IRQ];
   wire rtc_clr = st_wr && wdata[`SWDT_ST_RTC_IRQ];

   // a restore may land in the cycle of the request pulse or the one after
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_q <= 1'b0;
         since_edge <= 4'hF;
         req_q <= 1'b0;
      end
      else
      begin
         pin_q <= rtc_slow_clk_pin;
         req_q <= req;
         if (rtc_slow_clk_pin && !pin_q)
            since_edge <= 4'h0;
         else if (since_edge != 4'hF)
            since_edge <= since_edge + 4'h1;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_cpu_pulse: assert property (cpu_reset_req |=> !cpu_reset_req)
      else $error("cpu reset request longer than one cycle");
   a_main_pulse: assert property (main_sys_reset_req |=> !main_sys_reset_req)
      else $error("main reset request longer than one cycle");
   a_full_pulse: assert property (full_sys_reset_req |=> !full_sys_reset_req)
      else $error("full reset request longer than one cycle");
   a_main_irq_hold: assert property (main_wdog_irq && !main_clr && !req
      && !req_q |=> main_wdog_irq) else $error("main flag dropped");
   a_rtc_irq_hold: assert property (rtc_wdog_irq && !rtc_clr && !req
      && !req_q |=> rtc_wdog_irq) else $error("rtc flag dropped");
   a_status_flags: assert property (rd_en && addr == `SWDT_STATUS |=>
      rdata[5:4] == $past({rtc_wdog_irq, main_wdog_irq}))
      else $error("status flags differ from flag outputs");
   a_full_slow_edge: assert property (full_sys_reset_req |->
      since_edge <= 4'd8) else $error("full reset without slow edge");
   a_rtc_irq_edge: assert property ($rose(rtc_wdog_irq) |->
      since_edge <= 4'd8) else $error("rtc flag without slow edge");
   a_key_readback: assert property (wr_en && addr == `SWDT_MAIN_WKEY &&
      !req ##1 rd_en && addr == `SWDT_MAIN_WKEY && !req |=>
      rdata == $past(wdata, 2)) else $error("key read-back wrong");

   c_main_irq: cover property ($rose(main_wdog_irq));
   c_cpu: cover property (cpu_reset_req);
   c_main_sys: cover property (main_sys_reset_req);
   c_full: cover property (full_sys_reset_req);
endmodule

/* bench/swdt_top_tb.sv */
/*
 * Self-checking bench for the staged watchdog: strobe port tasks, key
 * guard, stage walk, feed, prescaler, action codes and rtc path.
 * Assumes swdt_top and swdt_top_asserts are compiled alongside.
 */
`timescale 1ns/1ns
`include "swdt_consts.vh"
module swdt_top_tb;
   localparam [31:0] EN = 32'h1 << `SWDT_CFG_EN;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0000_0000;
   reg wr_en = 1'b0;
   reg rd_en = 1'b0;
   reg pin = 1'b0;
   reg slow_run = 1'b0;
   wire [31:0] rdata;
   wire [4:0] outs;
   integer errors = 0;
   integer comparisons = 0;
   integer cycles = 0;
   integer sc = 0;
   integer i;
   reg [7:0] a8;
   reg [31:0] v;
   reg [31:0] k;
   reg [4:0] seen;
   reg [4:0] prev;

   swdt_top #(.TIMER_GROUP_ZERO(1), .SEL_W(2)) dut (
      .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .rtc_slow_clk_pin(pin), .fused_stage0_shift_sel(2'b01),
      .main_wdog_irq(outs[0]), .rtc_wdog_irq(outs[1]),
      .cpu_reset_req(outs[2]), .main_sys_reset_req(outs[3]),
      .full_sys_reset_req(outs[4]));

   // ****************************************
   // clocks and run limit
   // ****************************************
   always #2 clk = ~clk;

   // slow clock runs only while a test wants rtc ticks, 16 clk period
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (slow_run)
      begin
         sc <= (sc == 7) ? 0 : sc + 1;
         if (sc == 7)
            pin <= ~pin;
      end
      if (cycles == 20000)
      begin
         errors = errors + 1;
         results;
      end
   end

   // ****************************************
   // tasks
   // ****************************************
   task results;
   begin
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   task chk(input [31:0] s, input [31:0] e);
   begin
      comparisons = comparisons + 1;
      if (s !== e)
      begin
         errors = errors + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   end
   endtask

   // strobe stays up at return so calls can follow back to back
   task wr(input [7:0] a, input [31:0] d);
   begin
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      rd_en <= 1'b0;
      @(posedge clk);
   end
   endtask

   task rd(input [7:0] a, output [31:0] d);
   begin
      addr <= a;
      rd_en <= 1'b1;
      wr_en <= 1'b0;
      @(posedge clk);
      rd_en <= 1'b0;
      // data stand for the one cycle after the strobe edge
      @(posedge clk);
      d = rdata;
   end
   endtask

   task rdc(input [7:0] a, input [31:0] e);
   begin
      rd(a, v);
      chk(v, e);
   end
   endtask

   task watch(input integer n, input [4:0] e);
   begin
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      seen = 5'b00000;
      prev = outs;
      repeat (n)
      begin
         @(posedge clk);
         #1;
         seen = seen | (outs & ~prev);
         prev = outs;
      end
      chk({27'h0, seen}, {27'h0, e});
   end
   endtask

   task arm_main(input [31:0] cfg, input [15:0] pre, input [31:0] t);
   begin
      // stop the engine first so no stage expires halfway through setup
      wr(`SWDT_MAIN_WKEY, `SWDT_KEY);
      wr(`SWDT_MAIN_CFG, 32'h0000_0000);
      wr(`SWDT_MAIN_PRESCALE, {16'h0000, pre});
      wr(`SWDT_STATUS, 32'h0000_0010);
      for (a8 = `SWDT_MAIN_TMO0; a8 <= `SWDT_MAIN_TMO3; a8 = a8 + 8'h04)
         wr(a8, t);
      wr(`SWDT_MAIN_FEED, 32'h0000_0000);
      wr(`SWDT_MAIN_CFG, cfg);
   end
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(`SWDT_MAIN_CFG, `SWDT_MAIN_CFG_BOOT_RST);
      rdc(`SWDT_RTC_CFG, `SWDT_RTC_CFG_RST);
      rdc(`SWDT_MAIN_PRESCALE, {16'h0000, `SWDT_PRESCALE_RST});
      rdc(`SWDT_MAIN_WKEY, `SWDT_KEY_RST);
      $display("test reset values done");
      wr(`SWDT_MAIN_CFG, 32'h0000_0000);
      rdc(`SWDT_MAIN_CFG, `SWDT_MAIN_CFG_BOOT_RST);
      wr(`SWDT_MAIN_WKEY, `SWDT_KEY + 32'h1);
      rdc(`SWDT_MAIN_WKEY, `SWDT_KEY + 32'h1);
      wr(`SWDT_MAIN_CFG, 32'h0000_0000);
      rdc(`SWDT_MAIN_CFG, `SWDT_MAIN_CFG_BOOT_RST);
      wr(`SWDT_MAIN_WKEY, `SWDT_KEY);
      wr(`SWDT_MAIN_CFG, 32'h0000_0000);
      rdc(`SWDT_MAIN_CFG, 32'h0000_0000);
      for (a8 = `SWDT_MAIN_TMO0; a8 <= `SWDT_MAIN_TMO3; a8 = a8 + 8'h04)
         wr(a8, {24'h0, a8});
      for (a8 = `SWDT_MAIN_TMO0; a8 <= `SWDT_MAIN_TMO3; a8 = a8 + 8'h04)
         rdc(a8, {24'h0, a8});
      wr(`SWDT_MAIN_WKEY, 32'h0000_0000);
      wr(`SWDT_MAIN_TMO0, 32'h0000_0005);
      rdc(`SWDT_MAIN_TMO0, 32'h0000_0050);
      wr(`SWDT_RTC_WKEY, `SWDT_KEY);
      wr(`SWDT_RTC_CFG, 32'h0000_0008);
      rdc(`SWDT_RTC_CFG, 32'h0000_0008);
      $display("test write key done");
      arm_main(EN | `SWDT_ACT_IRQ, 16'h0001, 32'd20);
      for (i = 0; i < 5; i = i + 1)
      begin
         wr_en <= 1'b0;
         repeat ((i == 0) ? 10 : 18) @(posedge clk);
         rd(`SWDT_STATUS, v);
         chk(v[1:0], i % 4);
         chk(v[4], i != 0);
      end
      wr(`SWDT_STATUS, 32'h0000_0010);
      rdc(`SWDT_STATUS, {26'h0, 2'b00, 2'b00, 2'b00});
      wr(`SWDT_MAIN_CFG, {29'h0, `SWDT_ACT_IRQ});
      rd(`SWDT_MAIN_COUNT, k);
      chk(k < 20, 1);
      watch(40, 5'b00000);
      rdc(`SWDT_MAIN_COUNT, k);
      $display("test stages done");
      arm_main(EN | `SWDT_ACT_IRQ, 16'h0001, 32'd20);
      watch(15, 5'b00000);
      wr(`SWDT_MAIN_FEED, 32'h0000_0000);
      watch(15, 5'b00000);
      rd(`SWDT_STATUS, v);
      chk(v[1:0], 0);
      wr(`SWDT_MAIN_WKEY, 32'h0000_0000);
      wr(`SWDT_MAIN_FEED, 32'h0000_0000);
      watch(10, 5'b00001);
      rd(`SWDT_STATUS, v);
      chk(v[1:0], 1);
      $display("test feed done");
      arm_main(EN | `SWDT_ACT_CPU, 16'h0004, 32'd5);
      watch(15, 5'b00000);
      watch(12, 5'b00100);
      for (i = 1; i < 8; i = i + 1)
      begin
         arm_main(EN | i, 16'h0001, 32'd3);
         watch(10, (i == 1) ? 5'b00001 : (i == 2) ? 5'b00100 :
            (i == 3) ? 5'b01000 : 5'b00000);
         if (i == 3)
         begin
            rdc(`SWDT_MAIN_CFG, `SWDT_MAIN_CFG_BOOT_RST);
            rdc(`SWDT_MAIN_WKEY, `SWDT_KEY_RST);
            rdc(`SWDT_RTC_CFG, 32'h0000_0008);
         end
      end
      wr(`SWDT_MAIN_CFG, 32'h0000_0000);
      $display("test actions done");
      wr(`SWDT_RTC_TMO0, 32'h0000_0001);
      wr(`SWDT_RTC_TMO0 + 8'h04, 32'h0000_0002);
      wr(`SWDT_RTC_TMO0 + 8'h08, 32'h0000_0100);
      wr(`SWDT_RTC_TMO3, 32'h0000_0100);
      wr(`SWDT_RTC_CFG, EN | 32'h0000_000C);
      wr(`SWDT_RTC_FEED, 32'h0000_0000);
      slow_run <= 1'b1;
      watch(40, 5'b00000);
      watch(40, 5'b10000);
      watch(48, 5'b00010);
      rd(`SWDT_STATUS, v);
      chk(v[3:2], 2);
      rdc(`SWDT_RTC_CFG, EN | 32'h0000_000C);
      rdc(`SWDT_MAIN_CFG, `SWDT_MAIN_CFG_BOOT_RST);
      wr(`SWDT_RTC_CFG, 32'h0000_0000);
      slow_run <= 1'b0;
      $display("test rtc done");
      results;
   end
endmodule

bind swdt_top swdt_top_asserts #(.SEL_W(SEL_W)) u_chk (
   .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
   .rtc_slow_clk_pin(rtc_slow_clk_pin),
   .fused_stage0_shift_sel(fused_stage0_shift_sel),
   .main_wdog_irq(main_wdog_irq), .rtc_wdog_irq(rtc_wdog_irq),
   .cpu_reset_req(cpu_reset_req),
   .main_sys_reset_req(main_sys_reset_req),
   .full_sys_reset_req(full_sys_reset_req));
